// >>> core/exf_pkg.sv
// constants for the external function code interpreter
package exf_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_HOST = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_ILKL = 8'h08;
    localparam logic [7:0] A_ILKH = 8'h0c;
    localparam logic [7:0] A_INTS = 8'h10;

    // ------------------------------------------------------------
    // function code layout
    // ------------------------------------------------------------
    localparam int CODE_W = 19;
    localparam int B_GET  = 18;
    localparam int OP_NX0 = 3;
    localparam int OP_NX1 = 2;
    localparam int OP_SN0 = 1;
    localparam int OP_SN1 = 0;
    localparam logic [4:0] C_PORT = 5'h00;
    localparam logic [4:0] C_AINT = 5'h10;
    localparam logic [4:0] C_APCT = 5'h02;
    localparam logic [4:0] C_ERR  = 5'h04;
    localparam logic [4:0] C_ILK  = 5'h06;
    localparam logic [4:0] C_PGR  = 5'h08;
    localparam logic [7:0] N_ACT  = 8'h00;
    localparam logic [7:0] N_LOOP = 8'h01;

    // ------------------------------------------------------------
    // port switch buses, issuers, misc
    // ------------------------------------------------------------
    localparam logic [1:0] BUS_KEEP = 2'b00;
    localparam logic [1:0] BUS_SEQ  = 2'b01;
    localparam logic [1:0] BUS_INS  = 2'b10;
    localparam logic [1:0] BUS_PGR  = 2'b11;
    localparam int NPAGE  = 3;
    localparam int NISS   = 4;
    localparam int I_AP   = 0;
    localparam int I_PGR  = 1;
    localparam int I_SEQ  = 2;
    localparam int I_HOST = 3;
    localparam int ERR_ILLEGAL = 0;
    localparam logic [15:0] AP_FETCH_BASE = 16'h8000;

    // sense and next state chosen by present state: {sense, next}
    function automatic logic [1:0] sense_next(input logic cur, input logic [3:0] op);
        sense_next = cur ? {op[OP_SN1], op[OP_NX1]} : {op[OP_SN0], op[OP_NX0]};
    endfunction

endpackage

// >>> core/exf_arbiter.sv
// round-robin arbiter choosing one issuer at a time
`timescale 1ns/10ps
module exf_arbiter
    import exf_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic [NISS-1:0] req,
    input  wire logic            hold,
    output logic      [NISS-1:0] grant
);

    typedef struct packed {
        logic [1:0] last;
    } arb_t;

    arb_t st;
    arb_t nx;

    // ------------------------------------------------------------
    // pick next requester after the last one granted
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] idx;
        logic       found;
        idx   = '0;
        found = 1'b0;
        nx    = st;
        grant = '0;
        for (int i = 1; i <= NISS; i++) begin
            idx = st.last + 2'(i);
            if (!found && !hold && req[idx]) begin
                found      = 1'b1;
                grant[idx] = 1'b1;
                nx.last    = idx;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

endmodule

// >>> core/exf_logic.sv
// external function code interpreter with its state store
// ------------------------------------------------------------
// Functional notes
// R1: new-bus field chosen by present bus
// R2: port switch returns one of bits 29-31
// R3: 64 interlock flags, six-bit index
// R4: interlock state picks sense and next bit
// R5: interlocks 00-0F also on panel
// R6: pager off/busy sense and next state
// R7: fetch-address load always senses zero
// R8: fetch-address load breaks a block move
// R9: pager's pending code dropped on load
// R10: inoperative pager ignores fetch-address load
// R11: operative pager loads address, clears count
// R12: fifteen interrupt flags, 0F highest
// R13: priority mask from status word bits
// R14: accept only when all conditions hold
// R15: accepted interrupt fetches from 8000 plus n
// R16: interrupt code senses and sets state
// R17: inactive processor keeps its registers
// R18: activation fetches from 8000
// R19: activity code senses and sets activity
// R20: loop indicator held until loop ends
// R21: bit 29 clears loop indicator, ends loop
// R22: errors set indicators, error 00 halts
// R23: three page memories, one bus each
// R24: one code at a time, losers wait
// R25: 19-bit code senses and controls
// R26: issuer skips on sense one
// R27: reset clears flags, pager off, inactive
// ------------------------------------------------------------
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module exf_logic
    import exf_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    input  wire logic              ap_req,
    input  wire logic [CODE_W-1:0] ap_code,
    input  wire logic              pager_req,
    input  wire logic [CODE_W-1:0] pager_code,
    input  wire logic              seq_req,
    input  wire logic [CODE_W-1:0] seq_code,
    output logic      [NISS-1:0]   exf_ack,
    output logic                   exf_sense,
    output logic                   exf_dropped,
    output logic      [5:0]        port_switch,
    input  wire logic [15:0]       panel_set,
    input  wire logic [15:0]       panel_clr,
    output logic      [15:0]       panel_lamp,
    input  wire logic              pager_operative,
    input  wire logic              pager_moving,
    input  wire logic              pager_halt,
    output logic                   pager_busy,
    output logic      [15:0]       get_addr,
    output logic                   get_load,
    output logic                   pager_break,
    input  wire logic [3:0]        interrupt_priority_mask,
    input  wire logic              ap_interruptible,
    output logic                   fetch,
    output logic      [15:0]       fetch_addr,
    output logic                   ap_active,
    input  wire logic              loop_start,
    input  wire logic              loop_done,
    output logic                   loop_ind,
    output logic                   loop_abort,
    input  wire logic [15:0]       err_detect,
    output logic      [15:0]       err_ind,
    output logic                   seq_interrupt
);

    typedef struct packed {
        logic [63:0] ilk;
        logic [15:0] ap_int;
        logic [15:0] err;
        logic [5:0]  bus;
        logic        pager_busy;
        logic        ap_active;
        logic        loop_ind;
        logic [15:0] get_addr;
        logic        hold;
        logic [3:0]  ack;
        logic        sense;
        logic        dropped;
        logic        get_load;
        logic        pager_break;
        logic        loop_abort;
        logic        fetch;
        logic [15:0] fetch_addr;
        logic        seq_int;
        logic        host_pend;
        logic [18:0] host_code;
        logic        host_sense;
        logic [15:0] pset_m;
        logic [15:0] pset_s;
        logic [15:0] pclr_m;
        logic [15:0] pclr_s;
        logic        ahb_wr;
        logic [7:0]  ahb_addr;
        logic [31:0] rdata;
    } state_t;

    localparam state_t ST_RESET = '{bus: {NPAGE{BUS_INS}}, default: '0};

    state_t          st;
    state_t          nx;
    logic [NISS-1:0] grant;
    logic [NISS-1:0] req;
    logic [18:0]     code;
    logic [4:0]      cls;
    logic [7:0]      n;
    logic [3:0]      op;
    logic [3:0]      top;
    logic            take;

    function automatic logic [3:0] top_int(input logic [15:0] f);
        top_int = '0;
        for (int i = 1; i < 16; i++) begin
            if (f[i]) begin
                top_int = 4'(i);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // issuer selection and code fields
    // ------------------------------------------------------------
    assign req = {st.host_pend, seq_req, pager_req, ap_req};

    exf_arbiter u_arb (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .req      (req),
        .hold     (st.hold),
        .grant    (grant)
    );

    always_comb begin
        unique case (1'b1)
            grant[I_PGR]:  code = pager_code;
            grant[I_SEQ]:  code = seq_code;
            grant[I_HOST]: code = st.host_code;
            default:       code = ap_code;
        endcase
    end

    assign cls  = code[16:12];
    assign n    = code[11:4];
    assign op   = code[3:0];
    assign top  = top_int(st.ap_int);
    assign take = st.ap_active && ap_interruptible && top != '0             // [R14]
                  && interrupt_priority_mask < top && !st.fetch;            // [R13]

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] sn;
        logic [1:0] cur;
        logic [1:0] fld;
        logic       s;
        sn  = '0;
        cur = '0;
        fld = '0;
        s   = 1'b0;
        nx  = st;
        nx.ack         = '0;
        nx.dropped     = 1'b0;
        nx.get_load    = 1'b0;
        nx.pager_break = 1'b0;
        nx.loop_abort  = 1'b0;
        nx.fetch       = 1'b0;
        nx.hold        = |grant;                                     // [R24]
        nx.pset_m      = panel_set;
        nx.pset_s      = st.pset_m;
        nx.pclr_m      = panel_clr;
        nx.pclr_s      = st.pclr_m;
        nx.ilk[15:0]   = (st.ilk[15:0] | st.pset_s) & ~st.pclr_s;    // [R5]
        if (loop_done) begin
            nx.loop_ind = 1'b0;
        end
        if (loop_start) begin
            nx.loop_ind = 1'b1;                                      // [R20]
        end
        if (pager_halt || !pager_operative) begin
            nx.pager_busy = 1'b0;
        end
        if (|grant) begin
            nx.ack = grant;
            if (code[B_GET]) begin
                s = 1'b0;                                            // [R7]
                if (pager_req && !grant[I_PGR]) begin
                    nx.ack[I_PGR] = 1'b1;                            // [R9]
                    nx.dropped    = 1'b1;
                end
                if (pager_operative) begin                           // [R10]
                    nx.get_addr    = code[15:0];                     // [R11]
                    nx.get_load    = 1'b1;
                    nx.pager_busy  = 1'b1;
                    nx.pager_break = pager_moving;                   // [R8]
                end
            end else begin
                unique case (cls)                                    // [R25]
                    C_PORT: begin
                        if (n[7:6] != 2'b11) begin                   // [R23]
                            cur = st.bus[2*n[7:6] +: 2];
                            unique case (cur)
                                BUS_SEQ: begin
                                    fld = n[5:4];                    // [R1]
                                    s   = op[2];                     // [R2]
                                end
                                BUS_INS: begin
                                    fld = n[3:2];
                                    s   = op[OP_SN0];
                                end
                                BUS_PGR: begin
                                    fld = n[1:0];
                                    s   = op[OP_SN1];
                                end
                                default: begin
                                    fld = BUS_KEEP;
                                    s   = 1'b0;
                                end
                            endcase
                            if (fld != BUS_KEEP) begin
                                nx.bus[2*n[7:6] +: 2] = fld;
                            end
                        end
                    end
                    C_ILK: begin
                        if (n[7:6] == 2'b00) begin
                            sn = sense_next(st.ilk[n[5:0]], op);     // [R3]
                            s  = sn[1];                              // [R4]
                            nx.ilk[n[5:0]] = sn[0];
                        end
                    end
                    C_AINT: begin
                        if (n[7:4] == '0 && n[3:0] != '0) begin      // [R12]
                            sn = sense_next(st.ap_int[n[3:0]], op);
                            s  = sn[1];                              // [R16]
                            nx.ap_int[n[3:0]] = sn[0];
                        end
                    end
                    C_APCT: begin
                        if (n == N_ACT) begin
                            sn = sense_next(st.ap_active, op);
                            s  = sn[1];                              // [R19]
                            nx.ap_active = sn[0];
                        end else if (n == N_LOOP) begin
                            s = st.loop_ind ? op[OP_SN1] : op[OP_SN0];
                            if (op[OP_NX1]) begin                    // [R21]
                                nx.loop_ind   = loop_start;
                                nx.loop_abort = st.loop_ind;
                            end
                        end
                    end
                    C_ERR: begin
                        if (n[7:4] == '0) begin
                            sn = sense_next(st.err[n[3:0]], op);
                            s  = sn[1];
                            nx.err[n[3:0]] = sn[0];
                        end
                    end
                    C_PGR: begin
                        if (n == '0) begin
                            sn = sense_next(st.pager_busy, op);
                            s  = sn[1];                              // [R6]
                            nx.pager_busy = sn[0] && pager_operative;
                        end
                    end
                    default: begin
                        s = 1'b0;
                    end
                endcase
            end
        end
        nx.sense = s;                                                // [R26]
        if (grant[I_HOST]) begin
            nx.host_pend  = 1'b0;
            nx.host_sense = s;
        end
        nx.err = nx.err | err_detect;                                // [R22]
        if (err_detect[ERR_ILLEGAL]) begin
            nx.ap_active = 1'b0;
        end
        nx.seq_int = |nx.err;
        if (nx.ap_active && !st.ap_active) begin
            nx.fetch      = 1'b1;                                    // [R18]
            nx.fetch_addr = AP_FETCH_BASE;
        end else if (take) begin
            nx.fetch      = 1'b1;                                    // [R15]
            nx.fetch_addr = AP_FETCH_BASE + {12'h000, top};
        end
        // bus slave: address phase, then data phase
        if (st.ahb_wr && st.ahb_addr == A_HOST && !nx.host_pend) begin
            nx.host_pend = 1'b1;
            nx.host_code = hwdata[CODE_W-1:0];
        end
        nx.ahb_wr = 1'b0;
        nx.rdata  = '0;
        if (hready && hsel && htrans[1]) begin
            nx.ahb_wr   = hwrite;
            nx.ahb_addr = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    A_HOST: nx.rdata = {30'h0, st.host_sense, st.host_pend};
                    A_STAT: nx.rdata = {7'h00, st.ap_active, st.pager_busy,
                                        st.loop_ind, st.bus, st.err};
                    A_ILKL: nx.rdata = st.ilk[31:0];
                    A_ILKH: nx.rdata = st.ilk[63:32];
                    A_INTS: nx.rdata = {st.get_addr, st.ap_int};
                    default: nx.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= ST_RESET;                                          // [R27]
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = st.rdata;
    assign exf_ack       = st.ack;
    assign exf_sense     = st.sense;
    assign exf_dropped   = st.dropped;
    assign port_switch   = st.bus;
    assign panel_lamp    = st.ilk[15:0];
    assign pager_busy    = st.pager_busy;
    assign get_addr      = st.get_addr;
    assign get_load      = st.get_load;
    assign pager_break   = st.pager_break;
    assign fetch         = st.fetch;
    assign fetch_addr    = st.fetch_addr;
    assign ap_active     = st.ap_active;                             // [R17]
    assign loop_ind      = st.loop_ind;
    assign loop_abort    = st.loop_abort;
    assign err_ind       = st.err;
    assign seq_interrupt = st.seq_int;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence get_accept;
        |grant && code[B_GET];
    endsequence

    sequence pager_waiting;
        pager_req && !grant[I_PGR];
    endsequence

    one_code_a: assert property ($onehot0(grant)) // [R24]
        else $error("more than one code handled at once");
    ack_gap_a: assert property (exf_ack != '0 |-> grant == '0) // [R24]
        else $error("code taken in the cycle of an answer");
    ilk_state_a: assert property (|grant && !code[B_GET] && cls == C_ILK // [R4]
        && n[7:6] == 2'b00 |=> st.ilk[$past(n[5:0])] ==
        ($past(st.ilk[n[5:0]]) ? $past(op[OP_NX1]) : $past(op[OP_NX0])))
        else $error("interlock next state wrong");
    ilk_sense_a: assert property (|grant && !code[B_GET] && cls == C_ILK // [R4]
        && n[7:6] == 2'b00 && !st.ilk[n[5:0]] |=> exf_sense == $past(op[OP_SN0]))
        else $error("interlock sense bit wrong");
    get_zero_a: assert property (get_accept |=> !exf_sense) // [R7]
        else $error("load code sensed non-zero");
    get_inop_a: assert property (get_accept ##0 !pager_operative // [R10]
        |=> $stable(get_addr) && !get_load && !pager_busy)
        else $error("inoperative pager disturbed");
    get_load_a: assert property (get_accept ##0 pager_operative // [R11]
        |=> get_load && pager_busy && get_addr == $past(code[15:0]))
        else $error("fetch address not loaded");
    drop_pager_a: assert property (get_accept ##0 pager_waiting // [R9]
        |=> exf_ack[I_PGR] && exf_dropped ##1 exf_ack == '0)
        else $error("pending pager code not dropped");
    int_fetch_a: assert property (take && !(nx.ap_active && !st.ap_active) // [R15]
        |=> fetch && fetch_addr == AP_FETCH_BASE + {12'h000, $past(top)})
        else $error("interrupt fetch address wrong");
    start_fetch_a: assert property ($rose(ap_active) |-> fetch // [R18]
        && fetch_addr == AP_FETCH_BASE)
        else $error("activation fetch missing");
    err_halt_a: assert property (err_detect[ERR_ILLEGAL] |=> !ap_active // [R22]
        && err_ind[ERR_ILLEGAL] && seq_interrupt)
        else $error("illegal instruction error not handled");

endmodule

// >>> tb/exf_issuer.sv
// issuer model: raises a function code and waits for its answer
`timescale 1ns/10ps
module exf_issuer
    import exf_pkg::*;
(
    input  wire logic              core_clk,
    output logic                   req,
    output logic      [CODE_W-1:0] code,
    input  wire logic              ack,
    input  wire logic              sense
);
    // ----------------------------------------
    // one code per request, held until answered
    // ----------------------------------------
    int pc = 0;
    initial begin
        req = 1'b0;
        code = '0;
    end
    task automatic issue(input logic [CODE_W-1:0] c, output bit ok);
        ok = 1'b0;
        @(posedge core_clk);
        req <= 1'b1;
        code <= c;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge core_clk);
            ok = (ack === 1'b1);
        end
        req <= 1'b0;
        code <= ~c;
        pc = pc + ((sense === 1'b1) ? 2 : 1);
    endtask
endmodule

// >>> tb/external_function_logic_test.sv
// self-checking bench for the function code interpreter
`timescale 1ns/10ps
module external_function_logic_test import exf_pkg::*;;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, loop_start = 1'b0;
    logic pager_operative = 1'b0, pager_moving = 1'b0, ap_interruptible = 1'b1;
    logic hreadyout, hresp, ap_req, pager_req, seq_req, exf_sense, exf_dropped, pager_busy;
    logic get_load, pager_break, fetch, ap_active, loop_ind, loop_abort, seq_interrupt;
    logic brk = 1'b0, ab = 1'b0, loop_done = 1'b0;
    logic [15:0] panel_set = 16'h0000, panel_clr = 16'h0000;
    logic [1:0]  htrans = 2'b00, r;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  interrupt_priority_mask = 4'hf, exf_ack, op;
    logic [5:0]  port_switch, n;
    logic [15:0] err_detect = 16'h0000, panel_lamp, get_addr, fetch_addr, err_ind, fa = 16'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [63:0] ilk = 64'h0;
    logic [CODE_W-1:0] ap_code, pager_code, seq_code;
    logic        exp_q[$];
    int          failures = 0;
    int          checks_done = 0;

    exf_logic i_dut (.pager_halt(1'b0), .hready(hreadyout), .*);
    exf_issuer i_ap (.core_clk(core_clk), .req(ap_req), .code(ap_code),
                     .ack(exf_ack[I_AP]), .sense(exf_sense));
    exf_issuer i_pg (.core_clk(core_clk), .req(pager_req), .code(pager_code),
                     .ack(exf_ack[I_PGR]), .sense(exf_sense));
    exf_issuer i_sq (.core_clk(core_clk), .req(seq_req), .code(seq_code),
                     .ack(exf_ack[I_SEQ]), .sense(exf_sense));

    always #2 core_clk = ~core_clk;
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (pager_break === 1'b1 && get_load === 1'b1)
            brk <= 1'b1;
        if (loop_abort === 1'b1)
            ab <= 1'b1;
        if (fetch === 1'b1)
            fa <= fetch_addr;
        if (exf_ack !== 4'h0) begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk({31'h0, exf_sense}, {31'h0, exp_q.pop_front()});
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks_done++;
        if (got !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wt();
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (hreadyout === 1'b1)
                return;
        end
        failures++;
        wrap_up();
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wt();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wt();
        v = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(v, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic iss(input int w, input logic [CODE_W-1:0] c, input logic s);
        bit ok;
        exp_q.push_back(s);
        case (w)
            0: i_ap.issue(c, ok);
            1: i_pg.issue(c, ok);
            default: i_sq.issue(c, ok);
        endcase
        if (!ok) begin
            failures++;
            wrap_up();
        end
        @(posedge core_clk);
    endtask
    task automatic wfa(input logic [15:0] e);
        for (int i = 0; i < 16 && fa !== e; i++)
            @(posedge core_clk);
        chk({16'h0, fa}, {16'h0, e});
    endtask
    function automatic logic [CODE_W-1:0] mk(input logic [4:0] c, input logic [7:0] k,
                                              input logic [3:0] o);
        return {2'b00, c, k, o};
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h41db));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(A_STAT, 32'h002a0000);
        rd(8'h20, 32'h0);
        $display("reset values done");
        iss(2, 19'h007f0, 1'b0);
        iss(1, 19'h00950, 1'b0);
        chk({26'h0, port_switch}, 32'h1e);
        iss(0, 19'h005b1, 1'b1);
        iss(0, 19'h005b2, 1'b0);
        iss(2, 19'h009b4, 1'b1);
        $display("port switch done");
        for (int k = 0; k < 12; k++) begin
            n = 6'($urandom) & (k[0] ? 6'h3f : 6'h0f);
            op = 4'($urandom);
            r = ilk[n] ? {op[0], op[2]} : {op[1], op[3]};
            iss(k % 3, mk(C_ILK, {2'b00, n}, op), r[1]);
            ilk[n] = r[0];
        end
        rd(A_ILKL, ilk[31:0]);
        rd(A_ILKH, ilk[63:32]);
        chk({16'h0, panel_lamp}, {16'h0, ilk[15:0]});
        panel_set <= 16'h0003;
        panel_clr <= 16'h0004;
        repeat (4) @(posedge core_clk);
        panel_set <= 16'h0000;
        panel_clr <= 16'h0000;
        ilk[2:0] = 3'b011;
        chk({16'h0, panel_lamp}, {16'h0, ilk[15:0]});
        exp_q.push_back(ilk[63]);
        ahb(1'b1, A_HOST, {13'h0, mk(C_ILK, 8'h3f, 4'h5)});
        for (int i = 0; i < 10 && v[0] !== 1'b0 || i == 0; i++)
            ahb(1'b0, A_HOST, 32'h0);
        chk(v, {30'h0, ilk[63], 1'b0});
        $display("interlocks done");
        iss(1, 19'h4beef, 1'b0);
        chk({get_addr, 15'h0, pager_busy}, 32'h0);
        pager_operative <= 1'b1;
        pager_moving <= 1'b1;
        iss(2, 19'h4beef, 1'b0);
        chk({brk, get_addr, 14'h0, pager_busy}, 32'hdf778001);
        pager_moving <= 1'b0;
        iss(0, mk(C_PGR, 8'h00, 4'h6), 1'b0);
        iss(0, mk(C_PGR, 8'h00, 4'h0), 1'b0);
        chk({31'h0, pager_busy}, 32'h0);
        iss(1, mk(C_PGR, 8'h00, 4'h5), 1'b0);
        $display("pager done");
        iss(0, mk(C_APCT, N_ACT, 4'hc), 1'b0);
        wfa(16'h8000);
        interrupt_priority_mask <= 4'h5;
        iss(2, mk(C_AINT, 8'h05, 4'hc), 1'b0);
        chk({16'h0, fa}, 32'h8000);
        interrupt_priority_mask <= 4'h4;
        wfa(16'h8005);
        iss(1, mk(C_AINT, 8'h09, 4'hc), 1'b0);
        wfa(16'h8009);
        rd(A_INTS, 32'hbeef0220);
        iss(0, mk(C_AINT, 8'h05, 4'h5), 1'b1);
        $display("activity and interrupts done");
        loop_start <= 1'b1;
        @(posedge core_clk);
        loop_start <= 1'b0;
        err_detect <= 16'h0001;
        @(posedge core_clk);
        err_detect <= 16'h0000;
        repeat (2) @(posedge core_clk);
        chk({ap_active, loop_ind, seq_interrupt, err_ind}, 32'h00030001);
        iss(2, mk(C_APCT, N_LOOP, 4'h1), 1'b1);
        iss(0, mk(C_APCT, N_LOOP, 4'h4), 1'b0);
        chk({30'h0, loop_ind, ab}, 32'h1);
        iss(1, mk(C_ERR, 8'h00, 4'h1), 1'b1);
        chk({31'h0, seq_interrupt}, 32'h0);
        loop_start <= 1'b1;
        @(posedge core_clk);
        loop_start <= 1'b0;
        loop_done <= 1'b1;
        @(posedge core_clk);
        loop_done <= 1'b0;
        chk({31'h0, loop_ind}, 32'h1);
        @(posedge core_clk);
        chk({31'h0, loop_ind}, 32'h0);
        $display("loop and errors done");
        wrap_up();
    end
endmodule
